// File: common/nac_pkg.sv
package nac_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int NAC_NIB_W = 4;
    localparam int NAC_DR_W = 3;
    localparam int NAC_ROM_W = 10;
    localparam int NAC_PC_W = 13;
    localparam int NAC_PAGE_W = 6;
    localparam int NAC_LOW_W = 7;
    localparam int NAC_SP_W = 3;
    localparam int NAC_STACK_DEPTH = 8;

    // ------------------------------------------------------------
    // field positions in a rom word
    // ------------------------------------------------------------
    localparam int NAC_ROM_A_LSB = 0;
    localparam int NAC_ROM_B_LSB = 4;
    localparam int NAC_ROM_D_LSB = 8;

    // ------------------------------------------------------------
    // page limits per rom variant
    // ------------------------------------------------------------
    localparam logic [5:0] NAC_PAGE_MAX_SMALL = 6'h1F;
    localparam logic [5:0] NAC_PAGE_MAX_LARGE = 6'h3F;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] NAC_RST_NIB = 4'h0;
    localparam logic [2:0] NAC_RST_DR = 3'h0;
    localparam logic [2:0] NAC_RST_SP = 3'h0;
    localparam logic [12:0] NAC_RST_PC = 13'h0000;

    // ------------------------------------------------------------
    // operations issued by the sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        NAC_OP_NONE = 4'h0,
        NAC_OP_LOAD_ACC_IMMEDIATE = 4'h1,
        NAC_OP_TABLE_REFERENCE_CALL = 4'h2,
        NAC_OP_ADD_MEMORY = 4'h3,
        NAC_OP_ADD_MEMORY_WITH_CARRY = 4'h4,
        NAC_OP_ADD_IMMEDIATE = 4'h5,
        NAC_OP_AND_MEMORY = 4'h6,
        NAC_OP_OR_MEMORY = 4'h7
    } nac_op_t;

    // instruction issued for one cycle
    typedef struct packed {
        logic valid;
        nac_op_t op;
        logic [3:0] imm;
        logic [5:0] page;
    } nac_instr_t;

    // visible register state
    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] reg_b;
        logic [2:0] reg_d;
        logic carry_flag;
    } nac_regs_t;
endpackage

// File: rtl/nac_adder.sv
`timescale 1ns/10ps
`default_nettype none
// 4-bit adder with carry in, carry out of bit 3
module nac_adder (
    input wire logic [3:0] a, // first operand
    input wire logic [3:0] b, // second operand
    input wire logic cin, // carry in
    output logic [3:0] sum, // truncated sum
    output logic cout // carry out of bit 3
);
    logic [4:0] full;

    // ------------------------------------------------------------
    // add and split
    // ------------------------------------------------------------
    always_comb begin
        full = {1'b0, a} + {1'b0, b} + {4'h0, cin};
        sum = full[3:0];
        cout = full[4];
    end
endmodule
`default_nettype wire

// File: rtl/nac_alu.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - load immediate writes its nibble into A; carry untouched
// - in a run of load immediates only the first executes; others skipped
// - table call, upper flag 0: rom bits 7-4 to B, 3-0 to A
// - upper flag 1: also rom bits 9,8 into D (top D bit cleared)
// - table address is page p over D[2:0] then A[3:0]
// - table call pushes pc, fetches word, pops pc, sp up then down
// - add memory: A gets A plus memory nibble; carry untouched
// - add with carry: A gets A plus nibble plus carry; carry gets carry out
// - add immediate: A gets A plus n; carry untouched
// - add immediate skips next instruction when no overflow occurred
// - AND: A gets A and memory nibble
// - OR: A gets A or memory nibble
module nac_alu (
    input wire logic clk, // instruction clock
    input wire logic rst, // async reset, active high
    input wire nac_pkg::nac_instr_t instr, // instruction from sequencer
    input wire logic large_rom, // 1 selects the larger rom variant
    input wire logic upper_table_flag, // selects d loading on table call
    input wire logic [3:0] addressed_memory_nibble, // data at data pointer
    input wire logic [12:0] pc, // program counter of the call
    input wire logic [9:0] rom_data, // rom word, valid one cycle after rom_req
    output logic rom_req, // rom fetch strobe
    output logic [12:0] rom_addr, // rom fetch address
    output logic stack_push, // pulse: stack pointer up, pc pushed
    output logic stack_pop, // pulse: pc restored, stack pointer down
    output logic [12:0] pc_restore, // pc value popped from stack
    output logic [2:0] stack_pointer, // current stack pointer
    output logic busy, // table call in progress
    output logic skip_next, // pulse: next instruction is skipped
    output nac_pkg::nac_regs_t regs // A, B, D and carry
);
    import nac_pkg::*;

    // ------------------------------------------------------------
    // table call sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        NAC_ST_IDLE = 2'b00,
        NAC_ST_FETCH = 2'b01,
        NAC_ST_LOAD = 2'b10,
        NAC_ST_POP = 2'b11
    } nac_state_t;

    nac_state_t state_q, state_d;
    nac_regs_t regs_q, regs_d;
    logic last_was_load_q, last_was_load_d;
    logic skip_q, skip_d;
    logic [2:0] sp_q, sp_d;
    logic [12:0] stack_q [NAC_STACK_DEPTH];
    logic push_q, push_d;
    logic pop_q, pop_d;
    logic req_q, req_d;
    logic [12:0] addr_q, addr_d;
    logic [12:0] restore_q, restore_d;
    logic tab_upper_q, tab_upper_d;
    logic busy_q, busy_d;
    logic [3:0] add_b;
    logic add_cin;
    logic [3:0] add_sum;
    logic add_cout;
    logic [5:0] page_lim;

    // clamp page to the variant's range
    function automatic logic [5:0] clamp_page(input logic [5:0] p, input logic big);
        logic [5:0] lim;
        lim = big ? NAC_PAGE_MAX_LARGE : NAC_PAGE_MAX_SMALL;
        clamp_page = (p > lim) ? lim : p;
    endfunction

    // table address from page, D and A
    function automatic logic [12:0] table_addr(input logic [5:0] p, input logic [2:0] d,
                                                input logic [3:0] a);
        table_addr = {p, d, a};
    endfunction

    // ------------------------------------------------------------
    // shared adder
    // ------------------------------------------------------------
    always_comb begin
        add_b = addressed_memory_nibble;
        add_cin = 1'b0;
        if (instr.op == NAC_OP_ADD_IMMEDIATE) begin
            add_b = instr.imm;
        end
        if (instr.op == NAC_OP_ADD_MEMORY_WITH_CARRY) begin
            add_cin = regs_q.carry_flag;
        end
    end

    nac_adder u_adder (
        .a(regs_q.acc),
        .b(add_b),
        .cin(add_cin),
        .sum(add_sum),
        .cout(add_cout)
    );

    assign page_lim = clamp_page(instr.page, large_rom);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        regs_d = regs_q;
        last_was_load_d = last_was_load_q;
        skip_d = 1'b0;
        sp_d = sp_q;
        push_d = 1'b0;
        pop_d = 1'b0;
        req_d = 1'b0;
        addr_d = addr_q;
        restore_d = restore_q;
        tab_upper_d = tab_upper_q;
        case (state_q)
            NAC_ST_IDLE: begin
                if (instr.valid) begin
                    last_was_load_d = (instr.op == NAC_OP_LOAD_ACC_IMMEDIATE);
                    case (instr.op)
                        NAC_OP_LOAD_ACC_IMMEDIATE: begin
                            if (!last_was_load_q) begin
                                regs_d.acc = instr.imm;
                            end // later loads of a run are skipped
                        end
                        NAC_OP_TABLE_REFERENCE_CALL: begin
                            sp_d = sp_q + 3'h1;
                            push_d = 1'b1;
                            req_d = 1'b1;
                            addr_d = table_addr(page_lim, regs_q.reg_d, regs_q.acc);
                            tab_upper_d = upper_table_flag;
                            state_d = NAC_ST_FETCH;
                        end
                        NAC_OP_ADD_MEMORY: begin
                            regs_d.acc = add_sum;
                        end
                        NAC_OP_ADD_MEMORY_WITH_CARRY: begin
                            regs_d.acc = add_sum;
                            regs_d.carry_flag = add_cout;
                        end
                        NAC_OP_ADD_IMMEDIATE: begin
                            regs_d.acc = add_sum;
                            skip_d = ~add_cout;
                        end
                        NAC_OP_AND_MEMORY: begin
                            regs_d.acc = regs_q.acc & addressed_memory_nibble;
                        end
                        NAC_OP_OR_MEMORY: begin
                            regs_d.acc = regs_q.acc | addressed_memory_nibble;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            NAC_ST_FETCH: begin
                state_d = NAC_ST_LOAD; // rom_req high now; rom word arrives in LOAD
            end
            NAC_ST_LOAD: begin
                regs_d.reg_b = rom_data[NAC_ROM_B_LSB +: NAC_NIB_W];
                regs_d.acc = rom_data[NAC_ROM_A_LSB +: NAC_NIB_W];
                if (tab_upper_q) begin
                    regs_d.reg_d = {1'b0, rom_data[NAC_ROM_D_LSB +: 2]};
                end
                restore_d = stack_q[sp_q];
                state_d = NAC_ST_POP;
            end
            NAC_ST_POP: begin
                pop_d = 1'b1;
                sp_d = sp_q - 3'h1;
                state_d = NAC_ST_IDLE;
            end
            default: begin
                state_d = NAC_ST_IDLE;
            end
        endcase
        // busy registered so the port comes straight from a flop
        busy_d = (state_d != NAC_ST_IDLE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= NAC_ST_IDLE;
            regs_q <= '{acc: NAC_RST_NIB, reg_b: NAC_RST_NIB, reg_d: NAC_RST_DR,
                        carry_flag: 1'b0};
            last_was_load_q <= 1'b0;
            skip_q <= 1'b0;
            sp_q <= NAC_RST_SP;
            push_q <= 1'b0;
            pop_q <= 1'b0;
            req_q <= 1'b0;
            addr_q <= NAC_RST_PC;
            restore_q <= NAC_RST_PC;
            tab_upper_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            regs_q <= regs_d;
            last_was_load_q <= last_was_load_d;
            skip_q <= skip_d;
            sp_q <= sp_d;
            push_q <= push_d;
            pop_q <= pop_d;
            req_q <= req_d;
            addr_q <= addr_d;
            restore_q <= restore_d;
            tab_upper_q <= tab_upper_d;
            busy_q <= busy_d;
        end
    end

    // ------------------------------------------------------------
    // stack storage: written on push, no reset needed
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (push_d) begin
            stack_q[sp_d] <= pc;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flip-flops
    // ------------------------------------------------------------
    assign regs = regs_q;
    assign rom_req = req_q;
    assign rom_addr = addr_q;
    assign stack_push = push_q;
    assign stack_pop = pop_q;
    assign pc_restore = restore_q;
    assign stack_pointer = sp_q;
    assign busy = busy_q;
    assign skip_next = skip_q;
endmodule
`default_nettype wire

// File: sim/nac_alu_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module nac_alu_monitor (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire nac_pkg::nac_instr_t instr, // instruction
    input wire logic large_rom, // rom size
    input wire logic upper_table_flag, // d load select
    input wire logic [3:0] addressed_memory_nibble, // memory data
    input wire logic [12:0] pc, // call pc
    input wire logic [9:0] rom_data, // rom word
    input wire logic rom_req, // fetch
    input wire logic [12:0] rom_addr, // fetch address
    input wire logic stack_push, // push
    input wire logic stack_pop, // pop
    input wire logic [12:0] pc_restore, // popped pc
    input wire logic [2:0] stack_pointer, // sp
    input wire logic busy, // table call
    input wire logic skip_next, // skip
    input wire nac_pkg::nac_regs_t regs // registers
);
    import nac_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic tk, t_ld, t_tb, t_am, t_ac, t_ai, run_q;
    logic [3:0] a, nb;
    logic [4:0] isum;
    logic [5:0] pg;
    // decoded takes and operand helpers
    assign tk = instr.valid && !busy;
    assign t_ld = tk && instr.op == NAC_OP_LOAD_ACC_IMMEDIATE;
    assign t_tb = tk && instr.op == NAC_OP_TABLE_REFERENCE_CALL;
    assign t_am = tk && instr.op == NAC_OP_ADD_MEMORY;
    assign t_ac = tk && instr.op == NAC_OP_ADD_MEMORY_WITH_CARRY;
    assign t_ai = tk && instr.op == NAC_OP_ADD_IMMEDIATE;
    assign a = regs.acc;
    assign nb = addressed_memory_nibble;
    assign isum = {1'b0, a} + instr.imm;
    assign pg = (!large_rom && instr.page > NAC_PAGE_MAX_SMALL) ? NAC_PAGE_MAX_SMALL : instr.page;
    // tracks whether the last taken instruction was a load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
        end else if (tk) begin
            run_q <= t_ld;
        end
    end
    a_load_first: assert property (
        t_ld && !run_q |=> a == $past(instr.imm) && $stable(regs.carry_flag))
        else $error("load result wrong");
    a_load_skip: assert property (
        t_ld && run_q |=> $stable(a)) else $error("chained load not skipped");
    a_add_mem: assert property (
        t_am |=> a == 4'($past(a) + $past(nb)) && $stable(regs.carry_flag))
        else $error("add memory wrong");
    a_add_carry: assert property (
        t_ac |=> {regs.carry_flag, a} == {1'b0, $past(a)} + $past(nb) + $past(regs.carry_flag))
        else $error("add with carry wrong");
    a_add_imm_skip: assert property (
        t_ai |=> a == $past(isum[3:0]) && skip_next == !$past(isum[4]))
        else $error("add immediate wrong");
    a_table_start: assert property (
        t_tb |=> stack_push && rom_req && stack_pointer == $past(stack_pointer) + 3'h1
        && rom_addr == {$past(pg), $past(regs.reg_d), $past(a)}) else $error("table start wrong");
    a_table_load: assert property (
        t_tb |-> ##3 a == $past(rom_data[3:0]) && regs.reg_b == $past(rom_data[7:4])
        && regs.reg_d == ($past(upper_table_flag, 3) ? {1'b0, $past(rom_data[9:8])}
        : $past(regs.reg_d, 3))) else $error("table load wrong");
    a_table_end: assert property (
        t_tb |=> busy [*3] ##1 (stack_pop && !busy && pc_restore == $past(pc, 4)))
        else $error("table end wrong");
    c_table_up: cover property (t_tb && upper_table_flag);
    c_skip: cover property (skip_next);
    c_run: cover property (t_ld && run_q);
endmodule
bind nac_alu nac_alu_monitor u_nac_alu_monitor (.clk(clk), .rst(rst), .instr(instr),
    .large_rom(large_rom), .upper_table_flag(upper_table_flag),
    .addressed_memory_nibble(addressed_memory_nibble), .pc(pc), .rom_data(rom_data),
    .rom_req(rom_req), .rom_addr(rom_addr), .stack_push(stack_push), .stack_pop(stack_pop),
    .pc_restore(pc_restore), .stack_pointer(stack_pointer), .busy(busy),
    .skip_next(skip_next), .regs(regs));
`default_nettype wire

// File: sim/nac_alu_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module nac_alu_tb_top;
    import nac_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    nac_instr_t instr = '0;
    logic lrom = 1'b1;
    logic flag = 1'b0;
    logic [3:0] nib = 4'h0;
    logic [12:0] pc = 13'h0000;
    logic [9:0] rom_data = 10'h000;
    logic rom_req, stack_push, stack_pop, busy, skip_next;
    logic [12:0] rom_addr, pc_restore;
    logic [2:0] sp;
    nac_regs_t regs;
    int n_errors = 0;
    int checks = 0;
    logic cy = 1'b0;
    always #50 clk = ~clk;
    nac_alu u_nac_alu (.clk(clk), .rst(rst), .instr(instr), .large_rom(lrom),
        .upper_table_flag(flag), .addressed_memory_nibble(nib), .pc(pc),
        .rom_data(rom_data), .rom_req(rom_req), .rom_addr(rom_addr),
        .stack_push(stack_push), .stack_pop(stack_pop), .pc_restore(pc_restore),
        .stack_pointer(sp), .busy(busy), .skip_next(skip_next), .regs(regs));
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // issues one instruction, taken at the following edge
    task automatic send(nac_op_t op, logic [3:0] imm, logic [3:0] m);
        @(posedge clk);
        instr <= '{1'b1, op, imm, 6'h2A};
        nib <= m;
    endtask
    task automatic idle;
        @(posedge clk);
        instr.valid <= 1'b0;
        #1;
    endtask
    // every arithmetic and logic op on an overflowing and a plain pair
    task automatic t_arith;
        logic [4:0] s;
        logic [3:0] a, m;
        nac_op_t op;
        for (int p = 0; p < 2; p++) begin
            for (int k = 3; k < 8; k++) begin
                a = p ? 4'h3 : 4'hC;
                m = p ? 4'h4 : 4'h7;
                op = nac_op_t'(k);
                send(NAC_OP_LOAD_ACC_IMMEDIATE, a, 4'h0);
                // immediate and memory nibble differ, so a wrong operand shows
                send(op, (op == NAC_OP_ADD_IMMEDIATE) ? m : ~m,
                     (op == NAC_OP_ADD_IMMEDIATE) ? ~m : m);
                idle;
                case (op)
                    NAC_OP_AND_MEMORY: s = {1'b0, a & m};
                    NAC_OP_OR_MEMORY: s = {1'b0, a | m};
                    NAC_OP_ADD_MEMORY_WITH_CARRY: s = {1'b0, a} + m + cy;
                    default: s = {1'b0, a} + m;
                endcase
                if (op == NAC_OP_ADD_MEMORY_WITH_CARRY) begin
                    cy = s[4];
                end
                chk("acc", regs.acc, s[3:0]);
                chk("carry", regs.carry_flag, cy);
                chk("skip", skip_next, op == NAC_OP_ADD_IMMEDIATE && !s[4]);
            end
        end
        $display("arith test done");
    endtask
    // a run of loads with an idle cycle inside, then a no-op breaking it
    task automatic t_load_run;
        send(NAC_OP_LOAD_ACC_IMMEDIATE, 4'h5, 4'h0);
        send(NAC_OP_LOAD_ACC_IMMEDIATE, 4'h9, 4'h0);
        idle;
        send(NAC_OP_LOAD_ACC_IMMEDIATE, 4'h3, 4'h0);
        idle;
        chk("acc run", regs.acc, 4'h5);
        send(NAC_OP_NONE, 4'h0, 4'h0);
        send(NAC_OP_LOAD_ACC_IMMEDIATE, 4'hE, 4'h0);
        idle;
        chk("acc load", regs.acc, 4'hE);
        $display("load test done");
    endtask
    // one call at a time, so a stack level stays free
    task automatic t_table(logic f, logic lr, logic [3:0] a, logic [9:0] w, logic [2:0] d);
        logic [5:0] pg;
        pg = lr ? 6'h2A : 6'h1F;
        send(NAC_OP_NONE, 4'h0, 4'h0); // breaks a load run left by an earlier test
        send(NAC_OP_LOAD_ACC_IMMEDIATE, a, 4'h0);
        @(posedge clk);
        instr <= '{1'b1, NAC_OP_TABLE_REFERENCE_CALL, 4'h0, 6'h2A};
        flag <= f;
        lrom <= lr;
        pc <= 13'h1B35;
        @(posedge clk);
        instr.valid <= 1'b0;
        rom_data <= ~w; // word not yet due while rom_req stands
        #1;
        chk("push", {stack_push, rom_req, busy, sp}, {3'b111, 3'h1});
        chk("rom addr", rom_addr, {pg, d, a});
        @(posedge clk);
        rom_data <= w; // the cycle after rom_req, sampled at the next edge
        @(posedge clk);
        #1;
        chk("acc", regs.acc, w[3:0]);
        chk("b", regs.reg_b, w[7:4]);
        chk("d", regs.reg_d, f ? {1'b0, w[9:8]} : d);
        @(posedge clk);
        #1;
        chk("pop", {stack_pop, busy, sp}, {2'b10, 3'h0});
        chk("pc", pc_restore, 13'h1B35);
        $display("table test done");
    endtask
    // cuts a hang short
    initial begin
        #100000;
        n_errors++;
        final_report;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_arith;
        t_load_run;
        t_table(1'b1, 1'b1, 4'h5, 10'h2B6, 3'h0);
        t_table(1'b0, 1'b0, 4'h9, 10'h1C4, 3'h2);
        final_report;
    end
endmodule
`default_nettype wire
